// File: rtl/ensc_device.sv
// Sensor end: network state machine and position transmission scheduler
// Functional notes
// - Power-up: pre-operational, boot-up frame 700h+node
// - Pre-operational: no process data in or out
// - Command 80h enters pre-operational when addressed
// - Command 01h enters operational when addressed
// - Command 02h enters stopped when addressed
// - Target byte 00 all, else node match
// - 82h resets communication, 81h resets node
// - After either reset, rejoin pre-operational
// - Position process data only when operational
// - Polled: remote request answered, same identifier
// - Cyclic: send every 1 to 65536 ms
// - Sync: answer every (sync_skip+1)th sync, no offset delay
// - Sync counter skips configured syncs between answers
// - Master changes parameters only in pre-operational; the bench changes sync_skip and tx_mode while operational
// - Node number is stored setting plus one
`timescale 1ns/100ps
module ensc_device #(
	parameter int CYC_PER_MS = ensc_pkg::MS_CYCLES
) (
	// System
	input  wire logic                      clk,
	input  wire logic                      resetn,
	// Link
	ensc_link_if.dev                       link,
	// Configuration
	input  wire logic [7:0]                node_setting,
	input  wire logic [1:0]                tx_mode,
	input  wire logic [15:0]               cycle_ms_m1,
	input  wire logic [7:0]                sync_skip,
	// Position source
	input  wire logic [ensc_pkg::POS_W-1:0] position,
	input  wire logic [ensc_pkg::POS_W-1:0] pos_offset,
	// Status
	output logic [3:0]                     nmt_state,
	output logic                           comm_reset_pulse,
	output logic                           node_reset_pulse
);
	import ensc_pkg::*;

	ensc_state_type   state_r;
	ensc_state_type   state_nxt;
	logic [6:0]       node_id_r;
	logic             rx_ready_r;
	logic             tx_valid_r;
	logic [ID_W-1:0]  tx_id_r;
	logic [POS_W-1:0] tx_data_r;
	logic             pend_r;
	logic [15:0]      ms_cnt_r;
	logic [15:0]      cyc_cnt_r;
	logic [7:0]       sync_cnt_r;
	logic             comm_rst_r;
	logic             node_rst_r;
	logic             rx_fire;
	logic             nmt_hit;
	logic [7:0]       cmd;
	logic             ms_tick;
	logic             cyc_hit;
	logic             sync_hit;
	logic             rtr_hit;
	logic             trig;
	logic             tx_load;
	logic [ID_W-1:0]  pdo_id;

	localparam logic [15:0] MS_LAST = 16'(CYC_PER_MS - 1);

	function automatic logic node_match(input logic [7:0] tgt, input logic [6:0] node);
		node_match = (tgt == ALL_NODES) || (tgt == {1'b0, node});
	endfunction : node_match

	function automatic logic is_frame(input logic [ID_W-1:0] id, input logic [ID_W-1:0] want);
		is_frame = (id == want);
	endfunction : is_frame

	assign rx_fire = link.m2d_valid && rx_ready_r;
	assign cmd     = link.m2d_data[7:0];
	assign nmt_hit = rx_fire && !link.m2d_rtr && is_frame(link.m2d_id, NMT_ID)
		&& node_match(link.m2d_data[15:8], node_id_r);
	assign pdo_id  = PDO_BASE + {4'h0, node_id_r};

	// Stopped and pre-operational drop requests and syncs outright
	assign rtr_hit  = rx_fire && link.m2d_rtr && is_frame(link.m2d_id, pdo_id)
		&& state_r == ST_OPER && tx_mode == MODE_POLLED;
	assign sync_hit = rx_fire && !link.m2d_rtr && is_frame(link.m2d_id, SYNC_ID)
		&& state_r == ST_OPER && tx_mode == MODE_SYNC && sync_cnt_r == sync_skip;
	assign ms_tick  = ms_cnt_r == MS_LAST;
	assign cyc_hit  = ms_tick && cyc_cnt_r == cycle_ms_m1;
	assign trig     = rtr_hit || sync_hit || cyc_hit;
	assign tx_load  = !tx_valid_r && (state_r == ST_BOOT || (pend_r && state_r == ST_OPER));

	always_comb
	begin
		state_nxt = state_r;
		if (state_r == ST_BOOT)
		begin
			if (tx_load)
			begin
				state_nxt = ST_PREOP;
			end
		end
		else if (nmt_hit)
		begin
			case (cmd)
				CMD_PREOP:    state_nxt = ST_PREOP;
				CMD_START:    state_nxt = ST_OPER;
				CMD_STOP:     state_nxt = ST_STOPPED;
				CMD_RST_NODE: state_nxt = ST_BOOT;
				CMD_RST_COMM: state_nxt = ST_BOOT;
				default:      state_nxt = state_r;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_r <= ST_BOOT;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// Node number is relatched on every boot so a reset picks up a new setting
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			node_id_r <= NODE_DEFAULT[6:0] + NODE_INC;
		end
		else if (state_r == ST_BOOT)
		begin
			node_id_r <= node_setting[6:0] + NODE_INC;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			comm_rst_r <= 1'b0;
			node_rst_r <= 1'b0;
		end
		else
		begin
			comm_rst_r <= nmt_hit && state_r != ST_BOOT && cmd == CMD_RST_COMM;
			node_rst_r <= nmt_hit && state_r != ST_BOOT && cmd == CMD_RST_NODE;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rx_ready_r <= 1'b0;
		end
		else
		begin
			rx_ready_r <= 1'b1;
		end
	end

	// Millisecond divider and cycle counter only run while cyclic output is live
	always_ff @(posedge clk)
	begin
		if (!resetn || state_r != ST_OPER || tx_mode != MODE_CYCLIC)
		begin
			ms_cnt_r  <= '0;
			cyc_cnt_r <= '0;
		end
		else if (ms_tick)
		begin
			ms_cnt_r  <= '0;
			cyc_cnt_r <= cyc_hit ? 16'h0000 : cyc_cnt_r + 16'h0001;
		end
		else
		begin
			ms_cnt_r <= ms_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn || state_r != ST_OPER || tx_mode != MODE_SYNC)
		begin
			sync_cnt_r <= '0;
		end
		else if (rx_fire && !link.m2d_rtr && is_frame(link.m2d_id, SYNC_ID))
		begin
			sync_cnt_r <= sync_hit ? 8'h00 : sync_cnt_r + 8'h01;
		end
	end

	// A trigger in the load cycle survives, so it is not lost; triggers while one is pending merge into one frame
	always_ff @(posedge clk)
	begin
		if (!resetn || state_r != ST_OPER)
		begin
			pend_r <= 1'b0;
		end
		else if (trig)
		begin
			pend_r <= 1'b1;
		end
		else if (tx_load)
		begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			tx_valid_r <= 1'b0;
			tx_id_r    <= '0;
			tx_data_r  <= '0;
		end
		else if (tx_load)
		begin
			tx_valid_r <= 1'b1;
			if (state_r == ST_BOOT)
			begin
				tx_id_r   <= BOOT_BASE + {4'h0, node_setting[6:0] + NODE_INC};
				tx_data_r <= '0;
			end
			else
			begin
				tx_id_r   <= pdo_id;
				tx_data_r <= position + pos_offset;
			end
		end
		else if (tx_valid_r && link.d2m_ready)
		begin
			tx_valid_r <= 1'b0;
		end
	end

	assign link.m2d_ready  = rx_ready_r;
	assign link.d2m_valid  = tx_valid_r;
	assign link.d2m_id     = tx_id_r;
	assign link.d2m_data   = tx_data_r;
	assign nmt_state       = state_r;
	assign comm_reset_pulse = comm_rst_r;
	assign node_reset_pulse = node_rst_r;
endmodule : ensc_device

// File: pkg/ensc_pkg.sv
// Shared constants and types for the network state control block
package ensc_pkg;
	localparam int          CLK_HZ       = 25000000;
	localparam int          TICK_MS      = 1;
	localparam int          MS_CYCLES    = CLK_HZ / 1000 * TICK_MS;
	localparam int          ID_W         = 11;
	localparam int          POS_W        = 32;
	localparam int          FIFO_DEPTH   = 16;
	localparam logic [10:0] NMT_ID       = 11'h000;
	localparam logic [10:0] SYNC_ID      = 11'h080;
	localparam logic [10:0] PDO_BASE     = 11'h180;
	localparam logic [10:0] BOOT_BASE    = 11'h700;
	localparam logic [7:0]  CMD_START    = 8'h01;
	localparam logic [7:0]  CMD_STOP     = 8'h02;
	localparam logic [7:0]  CMD_PREOP    = 8'h80;
	localparam logic [7:0]  CMD_RST_NODE = 8'h81;
	localparam logic [7:0]  CMD_RST_COMM = 8'h82;
	localparam logic [7:0]  ALL_NODES    = 8'h00;
	localparam logic [7:0]  NODE_DEFAULT = 8'h1f;
	localparam logic [6:0]  NODE_INC     = 7'h01;
	localparam logic [1:0]  MODE_POLLED  = 2'h0;
	localparam logic [1:0]  MODE_CYCLIC  = 2'h1;
	localparam logic [1:0]  MODE_SYNC    = 2'h2;
	localparam logic [4:0]  REG_NMT      = 5'h00;
	localparam logic [4:0]  REG_SYNC     = 5'h04;
	localparam logic [4:0]  REG_RTR      = 5'h08;
	localparam logic [4:0]  REG_STATUS   = 5'h0c;
	localparam logic [4:0]  REG_RX_ID    = 5'h10;
	localparam logic [4:0]  REG_RX_DATA  = 5'h14;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	typedef enum logic [3:0] {
		ST_BOOT    = 4'h1,
		ST_PREOP   = 4'h2,
		ST_OPER    = 4'h4,
		ST_STOPPED = 4'h8
	} ensc_state_type;
endpackage : ensc_pkg

// File: pkg/ensc_link_if.sv
// Frame link between the network master end and the sensor end
`timescale 1ns/100ps
interface ensc_link_if;
	import ensc_pkg::*;
	logic              m2d_valid;
	logic              m2d_ready;
	logic [ID_W-1:0]   m2d_id;
	logic              m2d_rtr;
	logic [15:0]       m2d_data;
	logic              d2m_valid;
	logic              d2m_ready;
	logic [ID_W-1:0]   d2m_id;
	logic [POS_W-1:0]  d2m_data;
	modport dev  (input m2d_valid, m2d_id, m2d_rtr, m2d_data, d2m_ready,
		output m2d_ready, d2m_valid, d2m_id, d2m_data);
	modport host (output m2d_valid, m2d_id, m2d_rtr, m2d_data, d2m_ready,
		input m2d_ready, d2m_valid, d2m_id, d2m_data);
endinterface : ensc_link_if

// File: rtl/ensc_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
module ensc_fifo #(
	parameter int WIDTH = 43,
	parameter int DEPTH = 16
) (
	// System
	input  wire logic             clk,
	input  wire logic             resetn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr_r;
	logic [AW:0]      rptr_r;
	logic             push;
	logic             pop;

	// Extra pointer bit tells full from empty
	assign in_ready  = (wptr_r[AW] == rptr_r[AW]) || (wptr_r[AW-1:0] != rptr_r[AW-1:0]);
	assign out_valid = wptr_r != rptr_r;
	assign out_data  = mem[rptr_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			wptr_r <= '0;
			rptr_r <= '0;
		end
		else
		begin
			if (push)
			begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (pop)
			begin
				rptr_r <= rptr_r + 1'b1;
			end
		end
	end
endmodule : ensc_fifo

// File: rtl/ensc_host.sv
// Network master end: AXI4-Lite command registers and received position buffer
`timescale 1ns/100ps
module ensc_host #(
	parameter int DEPTH = ensc_pkg::FIFO_DEPTH
) (
	// System
	input  wire logic        clk,
	input  wire logic        resetn,
	// Link
	ensc_link_if.host        link,
	// AXI4-Lite write
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import ensc_pkg::*;

	localparam int FW = ID_W + POS_W;
	logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0]        bresp_r, rresp_r;
	logic [31:0]       rdata_r, wdata_r;
	logic [4:0]        awaddr_r;
	logic              tx_valid_r, tx_rtr_r;
	logic [ID_W-1:0]   tx_id_r;
	logic [15:0]       tx_data_r;
	logic              do_write, ar_fire, pop, f_valid, f_ready;
	logic [FW-1:0]     f_data;

	ensc_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_rx_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (link.d2m_valid),
		.in_ready  (f_ready),
		.in_data   ({link.d2m_id, link.d2m_data}),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data)
	);
	// A full buffer holds the sensor's frame until software drains it
	assign link.d2m_ready = f_ready;

	assign do_write = !awready_r && !wready_r && !bvalid_r;
	assign ar_fire  = s_axi_arvalid && arready_r;
	assign pop      = ar_fire && s_axi_araddr == REG_RX_DATA;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			awaddr_r  <= '0;
			wdata_r   <= '0;
		end
		else
		begin
			if (s_axi_awvalid && awready_r)
			begin
				awready_r <= 1'b0;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_r)
			begin
				wready_r <= 1'b0;
				wdata_r  <= s_axi_wdata;
			end
			if (do_write)
			begin
				bvalid_r <= 1'b1;
				bresp_r  <= (awaddr_r == REG_NMT || awaddr_r == REG_SYNC
					|| awaddr_r == REG_RTR) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_r && s_axi_bready)
			begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Writes while a frame is still waiting are dropped; status shows busy
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			tx_valid_r <= 1'b0;
			tx_rtr_r   <= 1'b0;
			tx_id_r    <= '0;
			tx_data_r  <= '0;
		end
		else if (do_write && !tx_valid_r && awaddr_r == REG_NMT)
		begin
			tx_valid_r <= 1'b1;
			tx_rtr_r   <= 1'b0;
			tx_id_r    <= NMT_ID;
			tx_data_r  <= wdata_r[15:0];
		end
		else if (do_write && !tx_valid_r && awaddr_r == REG_SYNC)
		begin
			tx_valid_r <= 1'b1;
			tx_rtr_r   <= 1'b0;
			tx_id_r    <= SYNC_ID;
			tx_data_r  <= '0;
		end
		else if (do_write && !tx_valid_r && awaddr_r == REG_RTR)
		begin
			tx_valid_r <= 1'b1;
			tx_rtr_r   <= 1'b1;
			tx_id_r    <= wdata_r[ID_W-1:0];
			tx_data_r  <= '0;
		end
		else if (tx_valid_r && link.m2d_ready)
		begin
			tx_valid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= '0;
			rresp_r   <= RESP_OKAY;
		end
		else if (ar_fire)
		begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= RESP_OKAY;
			case (s_axi_araddr)
				REG_STATUS:  rdata_r <= {29'h0, !f_ready, f_valid, tx_valid_r};
				REG_RX_ID:   rdata_r <= {21'h0, f_valid ? f_data[FW-1:POS_W] : 11'h000};
				REG_RX_DATA: rdata_r <= f_valid ? f_data[POS_W-1:0] : 32'h0000_0000;
				default:
				begin
					rdata_r <= '0;
					rresp_r <= RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_r && s_axi_rready)
		begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	assign link.m2d_valid = tx_valid_r;
	assign link.m2d_rtr   = tx_rtr_r;
	assign link.m2d_id    = tx_id_r;
	assign link.m2d_data  = tx_data_r;
	assign s_axi_awready  = awready_r;
	assign s_axi_wready   = wready_r;
	assign s_axi_bvalid   = bvalid_r;
	assign s_axi_bresp    = bresp_r;
	assign s_axi_arready  = arready_r;
	assign s_axi_rvalid   = rvalid_r;
	assign s_axi_rdata    = rdata_r;
	assign s_axi_rresp    = rresp_r;
endmodule : ensc_host

// File: verif/ensc_props.sv
// Concurrent checks on the frame link between the two ends
`timescale 1ns/100ps
module ensc_props (
	// System
	input wire logic        clk,
	input wire logic        resetn,
	// Master to sensor
	input wire logic        m2d_valid,
	input wire logic        m2d_ready,
	input wire logic [10:0] m2d_id,
	input wire logic [15:0] m2d_data,
	// Sensor to master
	input wire logic        d2m_valid,
	input wire logic        d2m_ready,
	input wire logic [10:0] d2m_id,
	input wire logic [31:0] d2m_data
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_reset_quiet: assert property ($rose(resetn) |-> !d2m_valid && !m2d_valid && !m2d_ready)
		else $error("link active out of reset");
	a_boot_frame: assert property ($rose(resetn) |=> ##[0:1] d2m_valid && d2m_id > 11'h700 && d2m_id <= 11'h77f)
		else $error("no boot frame after reset");
	a_boot_data: assert property (d2m_valid && d2m_id > 11'h6ff |-> d2m_data == 32'h0)
		else $error("boot frame carries data");
	a_node_nonzero: assert property (d2m_valid |-> d2m_id != 11'h700 && d2m_id != 11'h180)
		else $error("frame sent as node zero");
	a_frame_class: assert property (d2m_valid |-> d2m_id > 11'h700 || (d2m_id > 11'h180 && d2m_id <= 11'h200))
		else $error("frame id of unknown kind");
	a_dev_hold: assert property (d2m_valid && !d2m_ready |=> d2m_valid && $stable(d2m_id) && $stable(d2m_data))
		else $error("sensor frame changed while stalled");
	a_host_hold: assert property (m2d_valid && !m2d_ready |=> m2d_valid && $stable(m2d_id) && $stable(m2d_data))
		else $error("master frame changed while stalled");
	a_one_cmd: assert property (m2d_valid && m2d_ready |=> !m2d_valid)
		else $error("master frame repeated");
endmodule : ensc_props

// File: verif/testbench.sv
// Bench joining the master end and the sensor end across the frame link
`timescale 1ns/100ps
module testbench;
	import ensc_pkg::*;
	// Four cycles to the millisecond keeps cyclic runs short
	localparam int CPM = 4;
	logic        clk = 0;
	logic        resetn = 0;
	logic [4:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, position = 0, pos_offset = 0, rdata, nfr = 0, n0, rnd;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, crp_w, nrp_w;
	logic        crp = 0, nrp = 0;
	logic [1:0]  bresp, rresp, tx_mode = 0;
	logic [7:0]  node_setting = 0, sync_skip = 0, node;
	logic [15:0] cycle_ms_m1 = 0;
	logic [10:0] pdo_id, boot_id;
	logic [3:0]  nmt_state;
	logic [33:0] exp_q[$];
	logic [1:0]  b_q[$];
	int          error_cnt = 0, checks = 0, cyc = 0;
	ensc_link_if link ();
	ensc_device #(.CYC_PER_MS(CPM)) ensc_device_i (.clk, .resetn, .link, .node_setting,
		.tx_mode, .cycle_ms_m1, .sync_skip, .position, .pos_offset, .nmt_state,
		.comm_reset_pulse(crp_w), .node_reset_pulse(nrp_w));
	ensc_host #(.DEPTH(FIFO_DEPTH)) ensc_host_i (.clk, .resetn, .link,
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ensc_props ensc_props_i (.clk, .resetn, .m2d_valid(link.m2d_valid),
		.m2d_ready(link.m2d_ready), .m2d_id(link.m2d_id), .m2d_data(link.m2d_data),
		.d2m_valid(link.d2m_valid), .d2m_ready(link.d2m_ready), .d2m_id(link.d2m_id),
		.d2m_data(link.d2m_data));
	always #20 clk = ~clk;
	task automatic chk(input logic [33:0] got, input logic [33:0] want);
		checks++;
		if (got !== want)
		begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic close_out();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	// Read and write answers are compared in arrival order against the notes
	always @(posedge clk)
	begin
		if (link.d2m_valid && link.d2m_ready) nfr <= nfr + 1;
		if (crp_w) crp <= 1;
		if (nrp_w) nrp <= 1;
		if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
		if (bvalid && bready) chk({32'h0, bresp}, {32'h0, b_q.pop_front()});
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			close_out();
		end
	end
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		b_q.push_back(r);
		forever
		begin
			@(posedge clk);
			if (awready && awvalid) awvalid <= 0;
			if (wready && wvalid) wvalid <= 0;
			if (bvalid)
			begin
				bready <= 0;
				break;
			end
		end
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		exp_q.push_back({r, e});
		forever
		begin
			@(posedge clk);
			if (arready && arvalid) arvalid <= 0;
			if (rvalid)
			begin
				rready <= 0;
				break;
			end
		end
	endtask : rd
	task automatic st(input logic [3:0] e);
		chk({30'h0, nmt_state}, {30'h0, e});
	endtask : st
	task automatic cmd(input logic [7:0] c, input logic [7:0] t);
		wr(REG_NMT, {16'h0, t, c});
		idle(4);
	endtask : cmd
	task automatic rtr();
		wr(REG_RTR, {21'h0, pdo_id});
		idle(4);
	endtask : rtr
	task automatic frm(input logic [10:0] id, input logic [31:0] d);
		rd(REG_RX_ID, {21'h0, id});
		rd(REG_RX_DATA, d);
	endtask : frm
	initial
	begin
		void'($urandom(26));
		rnd = $urandom;
		// A stored setting of 7fh would wrap the node number to zero
		node = 8'(rnd % 127) + 8'h1;
		pdo_id = PDO_BASE + {3'h0, node};
		boot_id = BOOT_BASE + {3'h0, node};
		@(posedge clk);
		node_setting <= node - 8'h1;
		position <= $urandom;
		pos_offset <= $urandom;
		idle(10);
		resetn <= 1;
		idle(4);
		st(ST_PREOP);
		rd(REG_STATUS, 32'h2);
		frm(boot_id, 32'h0);
		rd(5'h18, 32'h0, RESP_SLVERR);
		wr(5'h1c, 32'h0, RESP_SLVERR);
		// Nothing answers before operation starts
		rtr();
		wr(REG_SYNC, 32'h0);
		idle(4);
		rd(REG_RX_ID, 32'h0);
		cmd(8'h03, ALL_NODES);
		st(ST_PREOP);
		cmd(CMD_START, node + 8'h1);
		st(ST_PREOP);
		cmd(CMD_START, node);
		st(ST_OPER);
		wr(REG_RTR, {21'h0, pdo_id + 11'h1});
		rtr();
		frm(pdo_id, position + pos_offset);
		rd(REG_RX_ID, 32'h0);
		// Seventeenth frame waits on the link while the buffer is full
		repeat (16) rtr();
		rd(REG_STATUS, 32'h6);
		rtr();
		repeat (17) frm(pdo_id, position + pos_offset);
		rd(REG_RX_ID, 32'h0);
		cmd(CMD_PREOP, node);
		st(ST_PREOP);
		// Mode is set while pre-operational; sync skip and polled mode change while operational
		tx_mode <= MODE_SYNC;
		cmd(CMD_START, ALL_NODES);
		st(ST_OPER);
		for (int k = 0; k < 3; k++)
		begin
			sync_skip <= k[7:0];
			position <= $urandom;
			repeat (k) wr(REG_SYNC, 32'h0);
			idle(4);
			rd(REG_RX_ID, 32'h0);
			wr(REG_SYNC, 32'h0);
			idle(4);
			frm(pdo_id, position + pos_offset);
		end
		tx_mode <= MODE_POLLED;
		cmd(CMD_STOP, ALL_NODES);
		st(ST_STOPPED);
		rtr();
		rd(REG_RX_ID, 32'h0);
		cmd(CMD_RST_COMM, ALL_NODES);
		st(ST_PREOP);
		chk({33'h0, crp}, 34'h1);
		chk({33'h0, nrp}, 34'h0);
		frm(boot_id, 32'h0);
		cmd(CMD_RST_NODE, node);
		st(ST_PREOP);
		chk({33'h0, nrp}, 34'h1);
		frm(boot_id, 32'h0);
		// Any 80 cycle window holds exactly ten 8 cycle periods
		cycle_ms_m1 <= 16'h1;
		tx_mode <= MODE_CYCLIC;
		cmd(CMD_START, node);
		idle(4);
		n0 = nfr;
		idle(80);
		chk({2'h0, nfr - n0}, 34'd10);
		cmd(CMD_STOP, node);
		n0 = nfr;
		idle(40);
		chk({2'h0, nfr - n0}, 34'd0);
		close_out();
	end
endmodule : testbench
